// *** core/status_pin_selector.sv ***
// module: status pin selector top with AXI4-Lite registers and event interrupt
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module status_pin_selector
  import status_pin_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // AXI4-Lite slave
  input  wire logic [11:0]  s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [11:0]  s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  // internal conditions
  input  wire logic         pri_signal_missing,
  input  wire logic         sec_signal_missing,
  input  wire logic         pll_unlocked,
  input  wire logic         r_div_half,
  input  wire logic         r_div_bypass,
  input  wire logic         n_div_half,
  input  wire logic         m_div_half,
  input  wire logic         m_div_bypass,
  input  wire logic         vco_cal_active,
  input  wire logic         irq_flags_summary,
  input  wire logic         nvm_active,
  input  wire logic         auto_switch_sec_to_pri,
  input  wire logic         detector_bypass,
  // test takeover
  input  wire pin_test_t    pin_a_test,
  input  wire pin_test_t    pin_b_test,
  // pins and interrupt
  output logic              status_pin_a,
  output logic              status_pin_b,
  output logic              irq
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  pin_cfg_t              cfg_a_q;
  pin_cfg_t              cfg_b_q;
  logic [EV_WIDTH-1:0]   irq_status_q;
  logic [EV_WIDTH-1:0]   irq_mask_q;
  logic [EV_WIDTH-1:0]   ev_level_q;

  logic                  aw_held_q;
  logic [11:0]           aw_addr_q;
  logic                  w_held_q;
  logic [31:0]           w_data_q;
  logic [3:0]            w_strb_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  rvalid_q;
  logic [31:0]           rdata_q;
  logic [1:0]            rresp_q;

  // ----------------------------------------------------------------
  // write channel capture: address and data taken in either order
  // ----------------------------------------------------------------
  logic        aw_take;
  logic        w_take;
  logic        wr_go;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic        wr_lane0;
  logic        wr_hit_a;
  logic        wr_hit_b;
  logic        wr_hit_st;
  logic        wr_hit_mk;
  logic        wr_hit_lv;
  logic        wr_mapped;

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign wr_go         = (aw_held_q || aw_take) && (w_held_q || w_take);
  assign wr_addr       = aw_held_q ? aw_addr_q : s_axi_awaddr;
  assign wr_data       = w_held_q ? w_data_q : s_axi_wdata;
  // all fields live in byte lane 0
  assign wr_lane0      = w_held_q ? w_strb_q[0] : s_axi_wstrb[0];
  assign wr_hit_a      = wr_go && (wr_addr == PIN_A_CTRL_ADDR);
  assign wr_hit_b      = wr_go && (wr_addr == PIN_B_CTRL_ADDR);
  assign wr_hit_st     = wr_go && (wr_addr == IRQ_STATUS_ADDR);
  assign wr_hit_mk     = wr_go && (wr_addr == IRQ_MASK_ADDR);
  assign wr_hit_lv     = wr_go && (wr_addr == PIN_LEVEL_ADDR);
  assign wr_mapped     = wr_hit_a || wr_hit_b || wr_hit_st || wr_hit_mk || wr_hit_lv;

  // hold whichever half of a write arrived first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end
    else
    begin
      aw_held_q <= wr_go ? 1'b0 : (aw_held_q || aw_take);
      w_held_q  <= wr_go ? 1'b0 : (w_held_q || w_take);
      if (aw_take)
        aw_addr_q <= s_axi_awaddr;
      if (w_take)
      begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  // write response, slave error on an unmapped address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_a_q    <= '{sel: PIN_A_SEL_RST, pol: PIN_A_POL_RST};
      cfg_b_q    <= '{sel: PIN_B_SEL_RST, pol: PIN_B_POL_RST};
      irq_mask_q <= IRQ_MASK_RST;
    end
    else if (wr_lane0)
    begin
      if (wr_hit_a)
        cfg_a_q <= '{sel: wr_data[SEL_MSB:SEL_LSB], pol: wr_data[POL_BIT]};
      if (wr_hit_b)
        cfg_b_q <= '{sel: wr_data[SEL_MSB:SEL_LSB], pol: wr_data[POL_BIT]};
      if (wr_hit_mk)
        irq_mask_q <= wr_data[EV_WIDTH-1:0];
    end
  end

  // ----------------------------------------------------------------
  // events: rising edges of loss, unlock and auto switch
  // ----------------------------------------------------------------
  logic [EV_WIDTH-1:0] ev_level;
  logic [EV_WIDTH-1:0] ev_rise;
  logic [EV_WIDTH-1:0] st_clear;

  // bypass is deliberately not used here: flags see the raw detectors
  assign ev_level = {auto_switch_sec_to_pri, pll_unlocked,
                     sec_signal_missing, pri_signal_missing};
  assign ev_rise  = ev_level & ~ev_level_q;
  assign st_clear = (wr_hit_st && wr_lane0) ? wr_data[EV_WIDTH-1:0] : {EV_WIDTH{1'b0}};

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ev_level_q   <= {EV_WIDTH{1'b0}};
      irq_status_q <= {EV_WIDTH{1'b0}};
    end
    else
    begin
      ev_level_q   <= ev_level;
      irq_status_q <= (irq_status_q & ~st_clear) | ev_rise;
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // ----------------------------------------------------------------
  // pin muxes
  // ----------------------------------------------------------------
  pin_sources_t src;
  logic         raw_a;
  logic         raw_b;

  assign src = '{pri_loss:    pri_signal_missing,
                 sec_loss:    sec_signal_missing,
                 unlock:      pll_unlocked,
                 r_div2:      r_div_half,
                 r_bypass:    r_div_bypass,
                 n_div2:      n_div_half,
                 vco_cal:     vco_cal_active,
                 irq_summary: irq_flags_summary,
                 m_div2:      m_div_half,
                 m_bypass:    m_div_bypass,
                 nvm_busy:    nvm_active,
                 auto_switch: auto_switch_sec_to_pri};

  status_pin_mux u_pin_a (
    .aclk    (aclk),
    .aresetn (aresetn),
    .src     (src),
    .cfg     (cfg_a_q),
    .test    (pin_a_test),
    .pin     (status_pin_a),
    .raw     (raw_a)
  );

  status_pin_mux u_pin_b (
    .aclk    (aclk),
    .aresetn (aresetn),
    .src     (src),
    .cfg     (cfg_b_q),
    .test    (pin_b_test),
    .pin     (status_pin_b),
    .raw     (raw_b)
  );

  // ----------------------------------------------------------------
  // read channel: one cycle to rvalid
  // ----------------------------------------------------------------
  logic        rd_take;
  logic [31:0] rd_word;
  logic        rd_mapped;

  assign s_axi_arready = !rvalid_q;
  assign rd_take       = s_axi_arvalid && s_axi_arready;
  assign rd_mapped     = (s_axi_araddr == PIN_A_CTRL_ADDR) || (s_axi_araddr == PIN_B_CTRL_ADDR) ||
                         (s_axi_araddr == IRQ_STATUS_ADDR) || (s_axi_araddr == IRQ_MASK_ADDR) ||
                         (s_axi_araddr == PIN_LEVEL_ADDR);
  // reserved bits 2:0 read as zero
  assign rd_word =
    (s_axi_araddr == PIN_A_CTRL_ADDR) ? {24'h00_0000, cfg_a_q.sel, cfg_a_q.pol, 3'h0} :
    (s_axi_araddr == PIN_B_CTRL_ADDR) ? {24'h00_0000, cfg_b_q.sel, cfg_b_q.pol, 3'h0} :
    (s_axi_araddr == IRQ_STATUS_ADDR) ? {28'h000_0000, irq_status_q} :
    (s_axi_araddr == IRQ_MASK_ADDR)   ? {28'h000_0000, irq_mask_q} :
    (s_axi_araddr == PIN_LEVEL_ADDR)  ? {28'h000_0000, raw_b, raw_a, status_pin_b, status_pin_a} :
    32'h0000_0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_pin_a_unlock: assert property (
    (cfg_a_q.sel == SRC_UNLOCK && cfg_a_q.pol && !pin_a_test.en) |=> (status_pin_a == $past(pll_unlocked)))
    else $error("pin a does not follow unlock");
  a_pin_a_rdiv: assert property (
    (cfg_a_q.sel == SRC_R_DIV2 && cfg_a_q.pol && r_div_bypass && !pin_a_test.en) |=> !status_pin_a)
    else $error("pin a shows bypassed r divider");
  a_pin_b_mdiv: assert property (
    (cfg_b_q.sel == SRC_M_DIV2 && cfg_b_q.pol && !m_div_bypass && !pin_b_test.en)
      |=> (status_pin_b == $past(m_div_half)))
    else $error("pin b does not follow m divider");
  a_pin_b_summary: assert property (
    (cfg_b_q.sel == SRC_IRQ_SUMMARY && !pin_b_test.en)
      |=> (status_pin_b == ($past(irq_flags_summary) ~^ $past(cfg_b_q.pol))))
    else $error("pin b summary wrong");
  a_pin_a_low: assert property (
    (cfg_a_q.sel == SRC_VCO_CAL && !cfg_a_q.pol && !pin_a_test.en) |=> (status_pin_a == !$past(vco_cal_active)))
    else $error("pin a polarity low wrong");
  a_pin_b_reset: assert property (
    $rose(aresetn) |-> (cfg_b_q.sel == SRC_UNLOCK && cfg_b_q.pol && cfg_a_q.pol))
    else $error("control reset values wrong");
  a_pin_b_low: assert property (
    (cfg_b_q.sel == SRC_NVM_BUSY && !cfg_b_q.pol && !pin_b_test.en) |=> (status_pin_b == !$past(nvm_active)))
    else $error("pin b polarity low wrong");
  a_test_a_wins: assert property (
    pin_a_test.en |=> (status_pin_a == $past(pin_a_test.level)))
    else $error("pin a test takeover lost");
  a_test_b_wins: assert property (
    pin_b_test.en |=> (status_pin_b == $past(pin_b_test.level)))
    else $error("pin b test takeover lost");
  a_loss_flag_set: assert property (
    $rose(pri_signal_missing) |=> irq_status_q[EV_PRI_LOSS])
    else $error("loss flag not set");
  a_bypass_kept: assert property (
    (detector_bypass && $rose(sec_signal_missing)) |=> irq_status_q[EV_SEC_LOSS])
    else $error("bypass hides secondary loss flag");
  a_reserved_off: assert property (
    (cfg_a_q.sel == 4'hF && !pin_a_test.en) |=> (status_pin_a == !$past(cfg_a_q.pol)))
    else $error("reserved code not inactive");

  c_write_a:   cover property (wr_hit_a && wr_lane0);
  c_irq_rise:  cover property ($rose(irq));
  c_read_b:    cover property (rd_take && s_axi_araddr == PIN_B_CTRL_ADDR);
  c_test_a:    cover property (pin_a_test.en ##1 !pin_a_test.en);

endmodule

`default_nettype wire

// *** core/status_pin_pkg.sv ***
// package: register map, field layout, reset values and source codes of the status pin selector
package status_pin_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0]  PIN_A_CTRL_IDX   = 8'h1B;
  localparam logic [7:0]  PIN_B_CTRL_IDX   = 8'h1C;
  localparam logic [7:0]  IRQ_STATUS_IDX   = 8'h20;
  localparam logic [7:0]  IRQ_MASK_IDX     = 8'h21;
  localparam logic [7:0]  PIN_LEVEL_IDX    = 8'h22;
  localparam logic [11:0] PIN_A_CTRL_ADDR  = {2'h0, PIN_A_CTRL_IDX, 2'h0};
  localparam logic [11:0] PIN_B_CTRL_ADDR  = {2'h0, PIN_B_CTRL_IDX, 2'h0};
  localparam logic [11:0] IRQ_STATUS_ADDR  = {2'h0, IRQ_STATUS_IDX, 2'h0};
  localparam logic [11:0] IRQ_MASK_ADDR    = {2'h0, IRQ_MASK_IDX, 2'h0};
  localparam logic [11:0] PIN_LEVEL_ADDR   = {2'h0, PIN_LEVEL_IDX, 2'h0};

  // field layout of the two pin control registers
  localparam int          SEL_MSB          = 7;
  localparam int          SEL_LSB          = 4;
  localparam int          POL_BIT          = 3;
  localparam logic [3:0]  PIN_A_SEL_RST    = 4'h5;
  localparam logic [3:0]  PIN_B_SEL_RST    = 4'h2;
  localparam logic        PIN_A_POL_RST    = 1'h1;
  localparam logic        PIN_B_POL_RST    = 1'h1;

  // event bits of the status and mask registers
  localparam int          EV_PRI_LOSS      = 0;
  localparam int          EV_SEC_LOSS      = 1;
  localparam int          EV_UNLOCK        = 2;
  localparam int          EV_AUTO_SWITCH   = 3;
  localparam int          EV_WIDTH         = 4;
  localparam logic [3:0]  IRQ_MASK_RST     = 4'h0;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  // source codes shared by both pins
  localparam logic [3:0]  SRC_PRI_LOSS     = 4'h0;
  localparam logic [3:0]  SRC_SEC_LOSS     = 4'h1;
  localparam logic [3:0]  SRC_UNLOCK       = 4'h2;
  localparam logic [3:0]  SRC_R_DIV2       = 4'h3;
  localparam logic [3:0]  SRC_N_DIV2       = 4'h4;
  localparam logic [3:0]  SRC_VCO_CAL      = 4'h8;
  localparam logic [3:0]  SRC_IRQ_SUMMARY  = 4'hA;
  localparam logic [3:0]  SRC_M_DIV2       = 4'hB;
  localparam logic [3:0]  SRC_NVM_BUSY     = 4'hD;
  localparam logic [3:0]  SRC_AUTO_SWITCH  = 4'hE;

  // all candidate sources presented to one pin mux
  typedef struct packed {
    logic pri_loss;
    logic sec_loss;
    logic unlock;
    logic r_div2;
    logic r_bypass;
    logic n_div2;
    logic vco_cal;
    logic irq_summary;
    logic m_div2;
    logic m_bypass;
    logic nvm_busy;
    logic auto_switch;
  } pin_sources_t;

  // one pin's programmed setting
  typedef struct packed {
    logic [3:0] sel;
    logic       pol;
  } pin_cfg_t;

  // test takeover of one pin
  typedef struct packed {
    logic en;
    logic level;
  } pin_test_t;

endpackage

// *** core/status_pin_mux.sv ***
// module: one status pin source mux with polarity and test takeover
`timescale 1ns/100ps
`default_nettype none

module status_pin_mux
  import status_pin_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire pin_sources_t src,
  input  wire pin_cfg_t     cfg,
  input  wire pin_test_t    test,
  output logic              pin,
  output logic              raw
);

  logic sel_raw;
  logic pin_d;
  logic pin_q;

  // source selection; reserved codes give an inactive raw level
  assign sel_raw =
    (cfg.sel == SRC_PRI_LOSS)    ? src.pri_loss :
    (cfg.sel == SRC_SEC_LOSS)    ? src.sec_loss :
    (cfg.sel == SRC_UNLOCK)      ? src.unlock :
    (cfg.sel == SRC_R_DIV2)      ? (src.r_div2 & ~src.r_bypass) :
    (cfg.sel == SRC_N_DIV2)      ? src.n_div2 :
    (cfg.sel == SRC_VCO_CAL)     ? src.vco_cal :
    (cfg.sel == SRC_IRQ_SUMMARY) ? src.irq_summary :
    (cfg.sel == SRC_M_DIV2)      ? (src.m_div2 & ~src.m_bypass) :
    (cfg.sel == SRC_NVM_BUSY)    ? src.nvm_busy :
    (cfg.sel == SRC_AUTO_SWITCH) ? src.auto_switch :
    1'b0;

  // polarity, then test takeover wins over both select and polarity
  assign pin_d = test.en ? test.level : (cfg.pol ? sel_raw : ~sel_raw);

  // registered pin so the output is glitch free during a select change
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin_q <= 1'b0;
    else
      pin_q <= pin_d;
  end

  assign pin = pin_q;
  assign raw = sel_raw;

endmodule

`default_nettype wire

// *** dv/pin_watch.sv ***
// partner model: board logic that watches both status pins and counts their rising edges
`timescale 1ns/100ps
`default_nettype none

module pin_watch
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       pin_a,
  input  wire logic       pin_b,
  output logic      [7:0] rise_a_q,
  output logic      [7:0] rise_b_q
);
  logic last_a_q;
  logic last_b_q;

  // --------------------------------------------------------------
  // edge counters
  // --------------------------------------------------------------
  // sampled on the clock, so a pulse shorter than a cycle is missed
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rise_a_q <= 8'h00;
      rise_b_q <= 8'h00;
    end
    else
    begin
      rise_a_q <= rise_a_q + {7'h00, pin_a & ~last_a_q};
      rise_b_q <= rise_b_q + {7'h00, pin_b & ~last_b_q};
    end
    last_a_q <= pin_a;
    last_b_q <= pin_b;
  end
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// testbench: self-checking bench of the status pin selector
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp, msg) begin compares++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH t=%0t %s", $time, msg); end end

module tb
  import status_pin_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, pa, pb, irq;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [9:0]  src = 10'h000;
  logic        r_byp = 1'b0, m_byp = 1'b0, det_byp = 1'b0;
  pin_test_t   ta = 2'b00, tb_t = 2'b00;
  logic [7:0]  ra, rb;
  int          err_total = 0;
  int          compares = 0;

  // --------------------------------------------------------------
  // clock, design and board monitor
  // --------------------------------------------------------------
  // src order: pri, sec, unlock, r/2, n/2, cal, irq, m/2, nvm, auto
  always #12.5 aclk = ~aclk;

  status_pin_selector i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pri_signal_missing(src[0]),
    .sec_signal_missing(src[1]), .pll_unlocked(src[2]), .r_div_half(src[3]), .r_div_bypass(r_byp),
    .n_div_half(src[4]), .m_div_half(src[7]), .m_div_bypass(m_byp), .vco_cal_active(src[5]),
    .irq_flags_summary(src[6]), .nvm_active(src[8]), .auto_switch_sec_to_pri(src[9]),
    .detector_bypass(det_byp), .pin_a_test(ta), .pin_b_test(tb_t), .status_pin_a(pa),
    .status_pin_b(pb), .irq(irq));

  pin_watch i_watch (.aclk(aclk), .aresetn(aresetn), .pin_a(pa), .pin_b(pb), .rise_a_q(ra), .rise_b_q(rb));

  // --------------------------------------------------------------
  // bus and helper tasks
  // --------------------------------------------------------------
  task automatic wrap_up;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ready is sampled mid-cycle; it cannot change before the next edge
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic ha, hw, hb;
    @(posedge aclk);
    awaddr <= a; wdata <= v; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(negedge aclk);
      ha = awvalid & awready; hw = wvalid & wready; hb = bvalid; resp = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb)
      begin
        bready <= 1'b0;
        return;
      end
    end
    `CHK(1'b1, 1'b0, "write timeout")
    wrap_up;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
    logic ha, hr;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(negedge aclk);
      ha = arvalid & arready; hr = rvalid; v = rdata; resp = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (hr)
      begin
        rready <= 1'b0;
        return;
      end
    end
    `CHK(1'b1, 1'b0, "read timeout")
    wrap_up;
  endtask

  // pins are registered: two edges leave them settled
  task automatic settle;
    repeat (2) @(posedge aclk);
    #1;
  endtask

  task automatic drive(input logic [9:0] s);
    @(posedge aclk);
    src <= s;
    settle;
  endtask

  function automatic int idx(input logic [3:0] c);
    case (c)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4: idx = int'(c);
      4'h8: idx = 5;
      4'hA: idx = 6;
      4'hB: idx = 7;
      4'hD: idx = 8;
      4'hE: idx = 9;
      default: idx = -1;
    endcase
  endfunction

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_reset;
    rd(PIN_A_CTRL_ADDR, d, r);
    `CHK(d, 32'h00000058, "pin a ctrl reset")
    rd(PIN_B_CTRL_ADDR, d, r);
    `CHK(d, 32'h00000028, "pin b ctrl reset")
    `CHK(pa, 1'b0, "pin a reset level")
  endtask

  // every code on both pins, a high and b low; lone source then all others, all sources at once for reserved codes
  task automatic t_route;
    int k;
    logic v;
    logic [9:0] oh;
    for (int c = 0; c < 16; c++)
    begin
      k = idx(c[3:0]);
      v = (k >= 0);
      oh = v ? (10'h001 << k) : 10'h3FF;
      wr(PIN_A_CTRL_ADDR, {24'h0, c[3:0], 4'h8}, r);
      wr(PIN_B_CTRL_ADDR, {24'h0, c[3:0], 4'h0}, r);
      rd(PIN_B_CTRL_ADDR, d, r);
      `CHK(d, {24'h0, c[3:0], 4'h0}, "pin b ctrl readback")
      drive(oh);
      `CHK(pa, v, "pin a selected source high")
      `CHK(pb, ~v, "pin b active low")
      if (!v)
        `CHK(pa, 1'b0, "reserved code inactive")
      if (v)
      begin
        drive(~oh);
        `CHK(pa, 1'b0, "pin a ignores other sources")
        `CHK(pb, 1'b1, "pin b ignores other sources")
      end
    end
  endtask

  task automatic t_bypass;
    wr(PIN_A_CTRL_ADDR, {24'h0, SRC_R_DIV2, 4'h8}, r);
    wr(PIN_B_CTRL_ADDR, {24'h0, SRC_M_DIV2, 4'h8}, r);
    @(posedge aclk);
    r_byp <= 1'b1;
    m_byp <= 1'b1;
    drive(10'h3FF);
    `CHK(pa, 1'b0, "r half hidden when bypassed")
    `CHK(pb, 1'b0, "m half hidden when bypassed")
    @(posedge aclk);
    r_byp <= 1'b0;
    m_byp <= 1'b0;
    settle;
    `CHK(pa, 1'b1, "r half shown")
    `CHK(pb, 1'b1, "m half shown")
  endtask

  task automatic t_test;
    logic [7:0] n0;
    logic [7:0] n1;
    wr(PIN_A_CTRL_ADDR, {24'h0, SRC_PRI_LOSS, 4'h8}, r);
    wr(PIN_B_CTRL_ADDR, {24'h0, SRC_PRI_LOSS, 4'h0}, r);
    drive(10'h001);
    n1 = rb;
    @(posedge aclk);
    ta <= 2'b10;
    tb_t <= 2'b11;
    settle;
    `CHK(pa, 1'b0, "test forces pin a low")
    `CHK(pb, 1'b1, "test forces pin b high")
    `CHK(rb, n1 + 8'h01, "board sees pin b rise")
    n0 = ra;
    @(posedge aclk);
    ta <= 2'b11;
    settle;
    `CHK(ra, n0 + 8'h01, "board sees one rise")
    @(posedge aclk);
    ta <= 2'b00;
    tb_t <= 2'b00;
    settle;
    `CHK(pb, 1'b0, "pin b back to setting")
  endtask

  task automatic t_detect;
    wr(PIN_B_CTRL_ADDR, {24'h0, SRC_SEC_LOSS, 4'h8}, r);
    // bypass raised before the losses rise, so a_bypass_kept sees it with the secondary loss rise
    @(posedge aclk);
    det_byp <= 1'b1;
    drive(10'h003);
    `CHK(pa, 1'b1, "primary loss kept")
    `CHK(pb, 1'b1, "secondary loss kept")
    @(posedge aclk);
    det_byp <= 1'b0;
    wr(PIN_A_CTRL_ADDR, {24'h0, SRC_VCO_CAL, 4'h0}, r);
    drive(10'h000);
    `CHK(pa, 1'b1, "pin a idle high when active low")
    drive(10'h020);
    `CHK(pa, 1'b0, "pin a active low")
    rd(PIN_LEVEL_ADDR, d, r);
    `CHK(d, 32'h00000004, "pin level readback")
  endtask

  task automatic t_irq;
    wr(IRQ_MASK_ADDR, 32'h4, r);
    wr(IRQ_STATUS_ADDR, 32'hF, r);
    drive(10'h000);
    `CHK(irq, 1'b0, "irq idle")
    drive(10'h004);
    `CHK(irq, 1'b1, "unlock event raises irq")
    rd(IRQ_STATUS_ADDR, d, r);
    `CHK(d, 32'h4, "unlock status bit")
    wr(IRQ_MASK_ADDR, 32'h0, r);
    `CHK(irq, 1'b0, "masked irq")
    wr(IRQ_STATUS_ADDR, 32'h4, r);
    wr(IRQ_MASK_ADDR, 32'h4, r);
    `CHK(irq, 1'b0, "cleared irq")
    rd(12'hFFC, d, r);
    `CHK(r, RESP_SLVERR, "unmapped read")
    wr(12'hFFC, 32'h1, r);
    `CHK(r, RESP_SLVERR, "unmapped write")
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    settle;
    t_reset;
    t_route;
    t_bypass;
    t_test;
    t_detect;
    t_irq;
    wrap_up;
  end
endmodule
`default_nettype wire
